/* fcs_err_pkg.sv */
package fcs_err_pkg;

  // Bus and field widths
  localparam int          DATA_W      = 32;               // APB data width
  localparam int          ADDR_W      = 12;               // Decoded APB address bits
  localparam int          STRB_W      = DATA_W / 8;       // Byte lanes
  localparam int          CNT_W_DEF   = 16;               // Tally field width
  localparam int          CNT_W_MAX   = 16;               // Field held in byte lanes 0 and 1
  localparam int          BYTE_BITS   = 8;                // Bits per byte lane
  localparam int          LEN_FRAC_W  = 3;                // Frame length bits below one byte

  // Register map, byte addresses
  localparam logic [11:0] OFF_COUNT   = 12'h000;          // Tally register
  localparam logic [11:0] OFF_SET     = 12'h004;          // Atomic set alias
  localparam logic [11:0] OFF_CLR     = 12'h008;          // Atomic clear alias
  localparam logic [11:0] OFF_INV     = 12'h00c;          // Atomic invert alias

  // Reset and fixed values
  localparam logic [15:0] COUNT_RST   = 16'h0000;         // Tally after reset
  localparam logic [31:0] RDATA_ZERO  = 32'h0000_0000;    // Idle or unmapped read data
  localparam logic [2:0]  LEN_ALIGNED = 3'h0;             // Length residue of a whole-byte frame
  localparam logic [1:0]  LOW_LANES_OFF = 2'h0;           // Both low byte enables deasserted

  // Write flavours of the four addresses
  typedef enum logic [1:0] {OP_DIRECT, OP_SET, OP_CLR, OP_INV} wr_op_t;

  // Address is one of the four mapped words
  function automatic logic addr_mapped(input logic [11:0] a);
    addr_mapped = (a == OFF_COUNT) || (a == OFF_SET) || (a == OFF_CLR) || (a == OFF_INV);
  endfunction

  // Address is the tally register itself
  function automatic logic addr_is_count(input logic [11:0] a);
    addr_is_count = (a == OFF_COUNT);
  endfunction

endpackage

/* rx_event_if.sv */
`timescale 1ns/1ps
// Qualified receive event between the qualifier and the tally
interface rx_event_if;
  logic inc;                                              // One-cycle count request
  modport src (output inc);
  modport dst (input  inc);
endinterface

/* rx_frame_qualifier.sv */
`timescale 1ns/1ps
module rx_frame_qualifier
  import fcs_err_pkg::*;
(
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  ce,
  input  wire logic                  rx_frame_done,
  input  wire logic                  rx_fcs_bad,
  input  wire logic [LEN_FRAC_W-1:0] rx_len_residue,
  rx_event_if.src                    ev
);

  // Registered state of the qualifier
  typedef struct packed {
    logic inc;                                            // Count request
  } qual_state_t;

  qual_state_t s_q;                                       // Current state
  qual_state_t s_d;                                       // Next state

  // Only receive completions with bad check sum and whole-byte length count
  always_comb
  begin
    s_d     = s_q;
    s_d.inc = rx_frame_done && rx_fcs_bad && (rx_len_residue == LEN_ALIGNED); // R01 R04
  end

  // State register, frozen while ce is low
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s_q <= '0;
    else if (ce)
      s_q <= s_d;
  end

  assign ev.inc = s_q.inc;

  // Bad whole-byte frame raises a request
  chk_qualify_bad: assert property (@(posedge pclk) disable iff (!presetn) // R01
    ce && rx_frame_done && rx_fcs_bad && rx_len_residue == LEN_ALIGNED |=> s_q.inc)
    else $error("bad whole-byte frame not counted");

  // Good or misaligned frames raise nothing
  chk_reject_other: assert property (@(posedge pclk) disable iff (!presetn) // R01
    ce && !(rx_frame_done && rx_fcs_bad && rx_len_residue == LEN_ALIGNED) |=> !s_q.inc)
    else $error("frame counted without qualifying");

endmodule

/* rx_crc_error_counter.sv */
// Design decisions made here: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
// What this block does
// R01: Count bad-FCS frames with whole-byte length
// R02: Tally in bits 15-0, upper bits zero
// R03: Read clears tally unless low enables off
// R04: Only receive activity increments the tally
// R05: Software writes tally only for debug
// R06: Increment survives clearing read; tally wraps
module rx_crc_error_counter
  import fcs_err_pkg::*;
#(
  parameter int CNT_W = CNT_W_DEF                         // Tally width
)
(
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  ce,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [ADDR_W-1:0]     paddr,
  input  wire logic [DATA_W-1:0]     pwdata,
  input  wire logic [STRB_W-1:0]     pstrb,
  output logic      [DATA_W-1:0]     prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic                  rx_frame_done,
  input  wire logic                  rx_fcs_bad,
  input  wire logic [LEN_FRAC_W-1:0] rx_len_residue,
  output logic      [CNT_W-1:0]      crc_error_tally
);

  // Refuse widths the two low byte lanes cannot hold
  generate
    if (CNT_W < 1 || CNT_W > CNT_W_MAX)
    begin : g_bad_width
      $error("CNT_W must be 1 to 16");
    end
  endgenerate

  // All registered state of the block except the qualifier's count request
  typedef struct packed {
    logic [CNT_W-1:0]  count;                             // The tally
    logic [CNT_W-1:0]  snap;                              // Value shown to the pending read
    logic [DATA_W-1:0] rdata;                             // Read data register
    logic              ready;                             // Access phase answer
    logic              err;                               // Unmapped address answer
  } cnt_state_t;

  cnt_state_t s_q;                                        // Current state
  cnt_state_t s_d;                                        // Next state

  rx_event_if ev ();                                      // Qualified event carrier

  // Frame status qualifier
  rx_frame_qualifier u_qual (
    .pclk           (pclk),
    .presetn        (presetn),
    .ce             (ce),
    .rx_frame_done  (rx_frame_done),
    .rx_fcs_bad     (rx_fcs_bad),
    .rx_len_residue (rx_len_residue),
    .ev             (ev)
  );

  // Byte enables spread over the tally bits
  function automatic logic [CNT_W-1:0] lane_mask(input logic [STRB_W-1:0] strb);
    logic [CNT_W-1:0] m;
    m = '0;
    for (int i = 0; i < CNT_W; i++)
      m[i] = strb[i / BYTE_BITS];
    lane_mask = m;
  endfunction

  logic             setup;                                // Setup phase of a transfer
  logic             access;                               // Completing access phase
  logic             rd_clear;                             // Read that clears the tally
  logic             wr_hit;                               // Write to a mapped word
  wr_op_t           op;                                   // Flavour of the write
  logic [CNT_W-1:0] wmask;                                // Lanes written
  logic [CNT_W-1:0] wval;                                 // Write data in tally width
  logic [CNT_W-1:0] base;                                 // Tally after write or clear

  // Bus phase decode
  always_comb
  begin
    setup    = psel && !penable;
    access   = psel && penable && s_q.ready;
    rd_clear = access && !pwrite && addr_is_count(paddr)
               && (pstrb[1:0] != LOW_LANES_OFF);          // R03
    wr_hit   = access && pwrite && addr_mapped(paddr);    // R05
    wmask    = lane_mask(pstrb);
    wval     = pwdata[CNT_W-1:0];
    case (paddr)
      OFF_SET: op = OP_SET;
      OFF_CLR: op = OP_CLR;
      OFF_INV: op = OP_INV;
      default: op = OP_DIRECT;
    endcase
  end

  // Next-state logic: bus answer, write, clearing read and increment
  always_comb
  begin
    s_d   = s_q;
    base  = s_q.count;
    if (setup)
    begin
      // Answer comes in the first access cycle
      s_d.ready = 1'b1;
      s_d.err   = !addr_mapped(paddr);
      s_d.snap  = s_q.count;
      if (!pwrite && addr_mapped(paddr))
        s_d.rdata = {{(DATA_W-CNT_W){1'b0}}, s_q.count}; // R02
      else
        s_d.rdata = RDATA_ZERO;
    end
    else
    begin
      // Answer lasts one cycle
      s_d.ready = 1'b0;
      s_d.err   = 1'b0;
      s_d.rdata = RDATA_ZERO;
    end
    if (rd_clear)
    begin
      // Remove only what the read reported
      base = s_q.count - s_q.snap;                        // R03 R06
    end
    else if (wr_hit)
    begin
      // Direct or atomic alias write, per byte lane
      case (op)
        OP_SET:  base = s_q.count | (wval & wmask);
        OP_CLR:  base = s_q.count & ~(wval & wmask);
        OP_INV:  base = s_q.count ^ (wval & wmask);
        default: base = (s_q.count & ~wmask) | (wval & wmask);
      endcase
    end
    // Increment applied last so it is never lost; wraps past all ones
    s_d.count = base + CNT_W'(ev.inc);                    // R01 R04 R06
  end

  // State register, frozen while ce is low
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_q       <= '0;
      s_q.count <= COUNT_RST[CNT_W-1:0];
    end
    else if (ce)
      s_q <= s_d;
  end

  // Outputs straight from the state register
  assign prdata          = s_q.rdata;
  assign pready          = s_q.ready;
  assign pslverr         = s_q.err;
  assign crc_error_tally = s_q.count;

  // Named steps of a read of the tally
  sequence seq_read_setup;
    ce && psel && !penable && !pwrite && addr_is_count(paddr) && !ev.inc;
  endsequence

  sequence seq_clear_access;
    ce && psel && penable && !pwrite && pstrb[1:0] != LOW_LANES_OFF && !ev.inc;
  endsequence

  // Upper half of read data is zero whenever answered
  chk_upper_zero: assert property (@(posedge pclk) disable iff (!presetn) // R02
    s_q.ready |-> s_q.rdata[DATA_W-1:CNT_W] == '0)
    else $error("unimplemented bits read nonzero");

  // Quiet increment adds exactly one
  chk_count_step: assert property (@(posedge pclk) disable iff (!presetn) // R01
    ce && ev.inc && !access && !wr_hit |=> s_q.count == CNT_W'($past(s_q.count) + 1'b1))
    else $error("increment did not add one");

  // Clearing read with no events leaves zero
  chk_read_clear: assert property (@(posedge pclk) disable iff (!presetn) // R03
    (seq_read_setup ##1 seq_clear_access) |=> s_q.count == '0)
    else $error("read did not clear tally");

  // Read with low lanes off keeps the tally
  chk_masked_read: assert property (@(posedge pclk) disable iff (!presetn) // R03
    ce && access && !pwrite && pstrb[1:0] == LOW_LANES_OFF && !ev.inc |=> $stable(s_q.count))
    else $error("masked read changed tally");

  // Event during clearing read survives
  chk_inc_kept: assert property (@(posedge pclk) disable iff (!presetn) // R06
    (seq_read_setup ##1 (ce && rd_clear && ev.inc)) |=> s_q.count == CNT_W'(1))
    else $error("increment lost at clearing read");

  // All ones wraps to zero
  chk_wrap: assert property (@(posedge pclk) disable iff (!presetn) // R06
    ce && ev.inc && !access && s_q.count == '1 |=> s_q.count == '0)
    else $error("tally did not wrap");

  // Setup phase is answered in the next cycle, for one cycle
  chk_ready_once: assert property (@(posedge pclk) disable iff (!presetn)
    ce && setup |=> s_q.ready ##1 (!ce || !s_q.ready))
    else $error("answer timing wrong");

  // Software side checks of the tally and the bus answer

  // Read answer carries the tally seen at setup
  chk_read_value: assert property (@(posedge pclk) disable iff (!presetn) // R02
    ce && setup && !pwrite && addr_mapped(paddr) |=> s_q.rdata == {{(DATA_W-CNT_W){1'b0}}, $past(s_q.count)})
    else $error("read data not the tally");

  // Write answer carries no data
  chk_write_rdata: assert property (@(posedge pclk) disable iff (!presetn)
    ce && setup && pwrite |=> s_q.rdata == RDATA_ZERO)
    else $error("write answer carried data");

  // Unmapped word is refused with zero data
  chk_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
    ce && setup && !addr_mapped(paddr) |=> s_q.err && s_q.rdata == RDATA_ZERO)
    else $error("unmapped word not refused");

  // Mapped words answer without error
  chk_mapped_ok: assert property (@(posedge pclk) disable iff (!presetn)
    ce && setup && addr_mapped(paddr) |=> !s_q.err)
    else $error("mapped word refused");

  // Nothing is answered without a setup phase
  chk_idle_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    ce && !setup |=> !s_q.ready && !s_q.err && s_q.rdata == RDATA_ZERO)
    else $error("answer without setup");

  // Error only ever comes with the answer
  chk_err_with_ready: assert property (@(posedge pclk) disable iff (!presetn)
    s_q.err |-> s_q.ready)
    else $error("error outside answer");

  // Setup records the value that the read reports
  chk_snap_taken: assert property (@(posedge pclk) disable iff (!presetn) // R06
    ce && setup |=> s_q.snap == $past(s_q.count))
    else $error("reported value not recorded");

  // Read of an alias word never clears
  chk_alias_read: assert property (@(posedge pclk) disable iff (!presetn)
    ce && access && !pwrite && !addr_is_count(paddr) && !ev.inc |=> $stable(s_q.count))
    else $error("alias read changed tally");

  // Refused write changes nothing
  chk_refused_write: assert property (@(posedge pclk) disable iff (!presetn)
    ce && access && pwrite && !addr_mapped(paddr) && !ev.inc |=> $stable(s_q.count))
    else $error("refused write changed tally");

  // Write with both low lanes off changes nothing
  chk_lanes_off_write: assert property (@(posedge pclk) disable iff (!presetn)
    ce && wr_hit && pstrb[1:0] == LOW_LANES_OFF && !ev.inc |=> $stable(s_q.count))
    else $error("write with low lanes off changed tally");

  // Full direct write replaces the tally
  chk_full_write: assert property (@(posedge pclk) disable iff (!presetn)
    ce && wr_hit && op == OP_DIRECT && pstrb == '1 && !ev.inc |=> s_q.count == $past(pwdata[CNT_W-1:0]))
    else $error("full write not applied");

  // Direct write replaces enabled lanes only
  chk_direct_write: assert property (@(posedge pclk) disable iff (!presetn)
    ce && wr_hit && op == OP_DIRECT && !ev.inc
    |=> s_q.count == (($past(s_q.count) & ~$past(wmask)) | ($past(wval) & $past(wmask))))
    else $error("lane write not applied");

  // Set alias raises enabled bits
  chk_set_write: assert property (@(posedge pclk) disable iff (!presetn)
    ce && wr_hit && op == OP_SET && !ev.inc |=> s_q.count == ($past(s_q.count) | ($past(wval) & $past(wmask))))
    else $error("set alias wrong");

  // Clear alias lowers enabled bits
  chk_clr_write: assert property (@(posedge pclk) disable iff (!presetn)
    ce && wr_hit && op == OP_CLR && !ev.inc |=> s_q.count == ($past(s_q.count) & ~($past(wval) & $past(wmask))))
    else $error("clear alias wrong");

  // Invert alias flips enabled bits
  chk_inv_write: assert property (@(posedge pclk) disable iff (!presetn)
    ce && wr_hit && op == OP_INV && !ev.inc |=> s_q.count == ($past(s_q.count) ^ ($past(wval) & $past(wmask))))
    else $error("invert alias wrong");

  // Write and event in one edge: write applied, then one more
  chk_write_inc: assert property (@(posedge pclk) disable iff (!presetn) // R06
    ce && wr_hit && op == OP_DIRECT && pstrb == '1 && ev.inc
    |=> s_q.count == CNT_W'($past(pwdata[CNT_W-1:0]) + 1'b1))
    else $error("increment lost at write");

  // Receive side checks of the tally

  // Tally holds when neither software nor receive acts
  chk_quiet_hold: assert property (@(posedge pclk) disable iff (!presetn) // R04
    ce && !ev.inc && !access |=> $stable(s_q.count))
    else $error("tally changed while quiet");

  // Masked read with an event adds exactly one
  chk_masked_inc: assert property (@(posedge pclk) disable iff (!presetn) // R06
    ce && access && !pwrite && pstrb[1:0] == LOW_LANES_OFF && ev.inc
    |=> s_q.count == CNT_W'($past(s_q.count) + 1'b1))
    else $error("increment lost at masked read");

  // Low clock enable freezes all state
  chk_frozen: assert property (@(posedge pclk) disable iff (!presetn)
    !ce |=> $stable(s_q))
    else $error("state moved while frozen");

endmodule

/* rx_path_model.sv */
`timescale 1ns/1ps
// Receive path stand-in: reports finished frames to the tally
module rx_path_model
  import fcs_err_pkg::*;
(
  input  wire logic                  pclk,
  output logic                       rx_frame_done,
  output logic                       rx_fcs_bad,
  output logic [LEN_FRAC_W-1:0]      rx_len_residue
);
  // Idle qualifiers look like a counting frame, so only the pulse may count
  initial
  begin
    rx_frame_done  = 1'b0;
    rx_fcs_bad     = 1'b1;
    rx_len_residue = 3'h0;
  end
  // Report n back-to-back frames with one result, then go idle for a cycle
  task automatic frame(input logic bad, input logic [LEN_FRAC_W-1:0] res, input int n);
    rx_frame_done  <= 1'b1;
    rx_fcs_bad     <= bad;
    rx_len_residue <= res;
    repeat (n) @(posedge pclk);
    rx_frame_done  <= 1'b0;
    rx_fcs_bad     <= ~bad;
    rx_len_residue <= ~res;
    @(posedge pclk);
  endtask
endmodule

/* tb.sv */
`timescale 1ns/1ps
// Self-checking bench for the receive error tally
module tb
  import fcs_err_pkg::*;
;
  logic                  pclk, presetn, ce, psel, penable, pwrite;  // Bus control, enable
  logic [ADDR_W-1:0]     paddr;                                 // Byte address
  logic [DATA_W-1:0]     pwdata, prdata, rdat;                  // Bus data, last read
  logic [STRB_W-1:0]     pstrb;                                 // Byte enables
  logic                  pready, pslverr, rerr;                 // Answer, last error
  logic                  rx_frame_done, rx_fcs_bad;             // Frame report
  logic [LEN_FRAC_W-1:0] rx_len_residue;                        // Length remainder
  logic [15:0]           crc_error_tally;                       // Tally view
  int                    mismatches, n_checks, cyc;             // Bench counters

  rx_crc_error_counter rx_crc_error_counter_inst (.pclk(pclk), .presetn(presetn), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_frame_done(rx_frame_done), .rx_fcs_bad(rx_fcs_bad), .rx_len_residue(rx_len_residue),
    .crc_error_tally(crc_error_tally));
  rx_path_model rx_path_model_inst (.pclk(pclk), .rx_frame_done(rx_frame_done),
    .rx_fcs_bad(rx_fcs_bad), .rx_len_residue(rx_len_residue));

  // Clock, 50 ns period
  always #25 pclk = ~pclk;

  // Hang guard
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      mismatches++;
      close_out();
    end
  end

  // Verdict and end of run
  task automatic close_out();
    if (mismatches == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Compare one value
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One bus transfer; holds the request until pready is seen at an edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd, input logic [3:0] st);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    pstrb   <= st;
    @(posedge pclk);
    penable <= 1'b1;
    // Wait for the answer; a wait that never sees pready ends only at the hang guard
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // Read and compare data and error
  task automatic rd(input logic [11:0] a, input logic [3:0] st, input logic [31:0] ev, input logic ee);
    apb(1'b0, a, 32'h0000_0000, st);
    check("read data", rdat, ev);
    check("read error", {31'h0, rerr}, {31'h0, ee});
  endtask

  // Write and compare error
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] st, input logic ee);
    apb(1'b1, a, d, st);
    check("write error", {31'h0, rerr}, {31'h0, ee});
  endtask

  // Main sequence
  initial
  begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    ce = 1'b1;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check("tally after reset", {16'h0, crc_error_tally}, 32'h0000_0000);
    rd(OFF_COUNT, 4'hf, 32'h0000_0000, 1'b0);
    // Every remainder with bad and good check; only bad whole-byte frames count
    for (int r = 0; r < 8; r++)
    begin
      rx_path_model_inst.frame(1'b1, 3'(r), 1);
      rx_path_model_inst.frame(1'b0, 3'(r), 1);
    end
    rd(OFF_COUNT, 4'hf, 32'h0000_0001, 1'b0);
    rd(OFF_COUNT, 4'hf, 32'h0000_0000, 1'b0);
    // Low lanes off keep the tally, low lane 1 alone clears it
    rx_path_model_inst.frame(1'b1, 3'h0, 3);
    rd(OFF_COUNT, 4'h0, 32'h0000_0003, 1'b0);
    rd(OFF_COUNT, 4'hc, 32'h0000_0003, 1'b0);
    rd(OFF_COUNT, 4'h2, 32'h0000_0003, 1'b0);
    rd(OFF_COUNT, 4'hf, 32'h0000_0000, 1'b0);
    // Debug write of all ones, upper half stays zero, then wrap
    wr(OFF_COUNT, 32'hffff_ffff, 4'hf, 1'b0);
    rd(OFF_SET, 4'hf, 32'h0000_ffff, 1'b0);
    rx_path_model_inst.frame(1'b1, 3'h0, 1);
    @(posedge pclk);
    check("tally wrap", {16'h0, crc_error_tally}, 32'h0000_0000);
    // Set, clear and invert aliases, then a single-lane direct write
    wr(OFF_SET, 32'h0000_00a5, 4'hf, 1'b0);
    wr(OFF_CLR, 32'h0000_0005, 4'hf, 1'b0);
    wr(OFF_INV, 32'h0000_00ff, 4'hf, 1'b0);
    rd(OFF_INV, 4'hf, 32'h0000_005f, 1'b0);
    wr(OFF_COUNT, 32'h1234_5678, 4'h2, 1'b0);
    // Unmapped word is refused and changes nothing
    wr(12'h010, 32'hffff_ffff, 4'hf, 1'b1);
    rd(12'h010, 4'hf, 32'h0000_0000, 1'b1);
    rd(OFF_COUNT, 4'hf, 32'h0000_565f, 1'b0);
    // Frame landing on the clearing edge is kept
    rx_path_model_inst.frame(1'b1, 3'h0, 2);
    fork
      rd(OFF_COUNT, 4'hf, 32'h0000_0002, 1'b0);
      rx_path_model_inst.frame(1'b1, 3'h0, 1);
    join
    check("tally after race", {16'h0, crc_error_tally}, 32'h0000_0001);
    // Frame landing on a full write edge, then on a masked read edge
    fork
      wr(OFF_COUNT, 32'h0000_1000, 4'hf, 1'b0);
      rx_path_model_inst.frame(1'b1, 3'h0, 1);
    join
    fork
      rd(OFF_COUNT, 4'h0, 32'h0000_1001, 1'b0);
      rx_path_model_inst.frame(1'b1, 3'h0, 1);
    join
    check("tally after masked read", {16'h0, crc_error_tally}, 32'h0000_1002);
    // Low clock enable drops a bad frame and keeps the tally
    ce <= 1'b0;
    rx_path_model_inst.frame(1'b1, 3'h0, 1);
    ce <= 1'b1;
    @(posedge pclk);
    check("tally while frozen", {16'h0, crc_error_tally}, 32'h0000_1002);
    // Reset in mid-run clears the tally; bus answers right after release
    presetn <= 1'b0;
    @(posedge pclk);
    check("tally in reset", {16'h0, crc_error_tally}, 32'h0000_0000);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(OFF_COUNT, 4'hf, 32'h0000_0000, 1'b0);
    close_out();
  end
endmodule
